// File: rtl/satc_device.sv
// Purpose: configuration and triggered stimulation registers of the device end
// Assumes: host keeps its own schedule; arm pin is asynchronous
// Notes:   outputs are the active values feeding the analog stimulators
`timescale 1ns/1ps
`default_nettype none
// Operation
// [R1] upper cut set by two two-field resistor words
// [R2] lower cut set by three select fields
// [R3] each channel drives positive or negative current
// [R4] each stimulator holds magnitude code plus trim
// [R5] one global three-field step size word
// [R6] host programs both biases to match step
// [R7] positive and negative magnitudes in two blocks
// [R8] on/off and polarity across two registers
// [R9] triggered writes land in shadow only
// [R10] shadow goes active only on commit flag
// [R11] commit moves all shadows at once
// [R12] no pulse timer; state holds until changed
// [R13] host builds biphasic pulse from separate commands
// [R14] host keeps a regular command schedule
// [R15] host corrects drift by adjusting trim
// [R16] stimulators off unless armed and unlocked
module satc_device
	import satc_pkg::*;
(
	// clock and reset
	input  wire logic                 ref_clk_i,
	input  wire logic                 reset_n_i,
	// link
	satc_link_if.device               link,
	// board pin
	input  wire logic                 stim_arm_i,
	// amplifier bandwidth
	output logic [5:0]                upper_cut_first_res_coarse_o,
	output logic [4:0]                upper_cut_first_res_fine_o,
	output logic [5:0]                upper_cut_second_res_coarse_o,
	output logic [4:0]                upper_cut_second_res_fine_o,
	output logic [6:0]                lower_cut_field_a_o,
	output logic [5:0]                lower_cut_field_b_o,
	output logic                      lower_cut_field_c_o,
	output logic [6:0]                lower_cut_alt_field_a_o,
	output logic [5:0]                lower_cut_alt_field_b_o,
	output logic                      lower_cut_alt_field_c_o,
	// stimulator globals
	output logic [6:0]                step_sel_one_o,
	output logic [5:0]                step_sel_two_o,
	output logic [1:0]                step_sel_three_o,
	output logic [3:0]                source_bias_o,
	output logic [3:0]                sink_bias_o,
	// per-channel active stimulation
	output logic [15:0]               stim_on_o,
	output logic [15:0]               stim_neg_o,
	output logic [15:0][15:0]         pos_mag_o,
	output logic [15:0][15:0]         neg_mag_o,
	output logic                      stim_enabled_o
);
	// true when addr falls inside the 16-register block at base
	function automatic logic in_block(input logic [7:0] addr, input logic [7:0] base);
		in_block = (addr[7:4] == base[7:4]);
	endfunction : in_block

	// plain configuration words
	logic [15:0]       upa_q, upa_d;   // first upper resistor
	logic [15:0]       upb_q, upb_d;   // second upper resistor
	logic [15:0]       lwa_q, lwa_d;   // lower cut normal
	logic [15:0]       lwb_q, lwb_d;   // lower cut recovery
	logic [15:0]       step_q, step_d; // step size selects
	logic [15:0]       bias_q, bias_d; // biases
	logic [31:0]       key_q, key_d;   // unlock registers
	// triggered registers: shadow and active copies
	logic [15:0]       on_sh_q, on_sh_d, on_q, on_d;
	logic [15:0]       pol_sh_q, pol_sh_d, pol_q, pol_d;
	logic [15:0][15:0] pos_sh_q, pos_sh_d, pos_q, pos_d;
	logic [15:0][15:0] neg_sh_q, neg_sh_d, neg_q, neg_d;
	// response and arm
	logic              rsp_v_q, rsp_v_d;
	logic [15:0]       rsp_q, rsp_d;
	logic              arm_meta_q, arm_q; // two-flop synchroniser
	logic              en_q, en_d;
	logic [15:0]       stim_on_q, stim_on_d; // gated on bits, kept in a flop for the pins
	logic              write_hit;         // write command this cycle

	// arm pin synchroniser, first flop read only by the second
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			arm_meta_q <= 1'b0;
			arm_q      <= 1'b0;
		end
		else
		begin
			arm_meta_q <= stim_arm_i;
			arm_q      <= arm_meta_q;
		end
	end

	assign write_hit = link.cmd_valid && link.cmd_write;

	// next values: writes, commit and readback
	always_comb
	begin
		upa_d    = upa_q;
		upb_d    = upb_q;
		lwa_d    = lwa_q;
		lwb_d    = lwb_q;
		step_d   = step_q;
		bias_d   = bias_q;
		key_d    = key_q;
		on_sh_d  = on_sh_q;
		pol_sh_d = pol_sh_q;
		pos_sh_d = pos_sh_q;
		neg_sh_d = neg_sh_q;
		rsp_v_d  = link.cmd_valid;
		rsp_d    = rsp_q;
		if (write_hit)
		begin
			unique case (link.cmd_addr)
				SATC_REG_UPPER_A:  upa_d = link.cmd_data; // [R1]
				SATC_REG_UPPER_B:  upb_d = link.cmd_data; // [R1]
				SATC_REG_LOWER_A:  lwa_d = link.cmd_data; // [R2]
				SATC_REG_LOWER_B:  lwb_d = link.cmd_data; // [R2]
				SATC_REG_STEP:     step_d = link.cmd_data; // [R5]
				SATC_REG_BIAS:     bias_d = link.cmd_data; // [R6]
				SATC_REG_UNLOCK_L: key_d[15:0] = link.cmd_data; // [R16]
				SATC_REG_UNLOCK_H: key_d[31:16] = link.cmd_data; // [R16]
				SATC_REG_ON:       on_sh_d = link.cmd_data; // [R8] [R9]
				SATC_REG_POL:      pol_sh_d = link.cmd_data; // [R8] [R9]
				default:
				begin
					// magnitude blocks; anything else is ignored
					if (in_block(link.cmd_addr, SATC_REG_POS_BASE))
						pos_sh_d[link.cmd_addr[3:0]] = link.cmd_data; // [R4] [R7] [R9]
					else if (in_block(link.cmd_addr, SATC_REG_NEG_BASE))
						neg_sh_d[link.cmd_addr[3:0]] = link.cmd_data; // [R4] [R7] [R9]
				end
			endcase
			rsp_d = link.cmd_data; // writes echo their data
		end
		else if (link.cmd_valid)
		begin
			// reads show active values, so software sees what drives the outputs
			unique case (link.cmd_addr)
				SATC_REG_UPPER_A:  rsp_d = upa_q;
				SATC_REG_UPPER_B:  rsp_d = upb_q;
				SATC_REG_LOWER_A:  rsp_d = lwa_q;
				SATC_REG_LOWER_B:  rsp_d = lwb_q;
				SATC_REG_STEP:     rsp_d = step_q;
				SATC_REG_BIAS:     rsp_d = bias_q;
				SATC_REG_UNLOCK_L: rsp_d = key_q[15:0];
				SATC_REG_UNLOCK_H: rsp_d = key_q[31:16];
				SATC_REG_ON:       rsp_d = on_q;
				SATC_REG_POL:      rsp_d = pol_q;
				default:
				begin
					if (in_block(link.cmd_addr, SATC_REG_POS_BASE))
						rsp_d = pos_q[link.cmd_addr[3:0]];
					else if (in_block(link.cmd_addr, SATC_REG_NEG_BASE))
						rsp_d = neg_q[link.cmd_addr[3:0]];
					else
						rsp_d = 16'h0000; // unmapped reads as zero
				end
			endcase
		end
		// commit: a write carrying the flag is included in the same commit
		if (link.cmd_valid && link.cmd_update) // [R10]
		begin
			on_d  = on_sh_d;  // [R11]
			pol_d = pol_sh_d; // [R11]
			pos_d = pos_sh_d; // [R11]
			neg_d = neg_sh_d; // [R11]
		end
		else
		begin
			// no timer here: active state holds until the next commit
			on_d  = on_q;  // [R12]
			pol_d = pol_q; // [R12]
			pos_d = pos_q;
			neg_d = neg_q;
		end
		en_d = arm_q && (key_q == SATC_UNLOCK_CODE); // [R16]
		// gate from next values so the pins track on_q & en_q with no extra lag
		stim_on_d = on_d & {SATC_CHANNELS{en_d}}; // [R16] [R3]
	end

	// register all state
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			upa_q    <= SATC_RST_WORD;
			upb_q    <= SATC_RST_WORD;
			lwa_q    <= SATC_RST_WORD;
			lwb_q    <= SATC_RST_WORD;
			step_q   <= SATC_RST_WORD;
			bias_q   <= SATC_RST_WORD;
			key_q    <= 32'h0000_0000;
			on_sh_q  <= SATC_RST_WORD;
			pol_sh_q <= SATC_RST_WORD;
			on_q     <= SATC_RST_WORD;
			pol_q    <= SATC_RST_WORD;
			pos_sh_q <= {SATC_CHANNELS{SATC_RST_TRIM}};
			neg_sh_q <= {SATC_CHANNELS{SATC_RST_TRIM}};
			pos_q    <= {SATC_CHANNELS{SATC_RST_TRIM}};
			neg_q    <= {SATC_CHANNELS{SATC_RST_TRIM}};
			rsp_v_q  <= 1'b0;
			rsp_q    <= SATC_RST_WORD;
			en_q     <= 1'b0;
			stim_on_q <= SATC_RST_WORD;
		end
		else
		begin
			upa_q    <= upa_d;
			upb_q    <= upb_d;
			lwa_q    <= lwa_d;
			lwb_q    <= lwb_d;
			step_q   <= step_d;
			bias_q   <= bias_d;
			key_q    <= key_d;
			on_sh_q  <= on_sh_d;
			pol_sh_q <= pol_sh_d;
			on_q     <= on_d;
			pol_q    <= pol_d;
			pos_sh_q <= pos_sh_d;
			neg_sh_q <= neg_sh_d;
			pos_q    <= pos_d;
			neg_q    <= neg_d;
			rsp_v_q  <= rsp_v_d;
			rsp_q    <= rsp_d;
			en_q     <= en_d;
			stim_on_q <= stim_on_d;
		end
	end

	// output fields, all straight from flops
	assign link.rsp_valid = rsp_v_q;
	assign link.rsp_data  = rsp_q;
	assign upper_cut_first_res_coarse_o  = upa_q[SATC_UC_COARSE_LSB +: 6];
	assign upper_cut_first_res_fine_o    = upa_q[SATC_UC_FINE_LSB +: 5];
	assign upper_cut_second_res_coarse_o = upb_q[SATC_UC_COARSE_LSB +: 6];
	assign upper_cut_second_res_fine_o   = upb_q[SATC_UC_FINE_LSB +: 5];
	assign lower_cut_field_a_o     = lwa_q[SATC_LC_A_LSB +: 7];
	assign lower_cut_field_b_o     = lwa_q[SATC_LC_B_LSB +: 6];
	assign lower_cut_field_c_o     = lwa_q[SATC_LC_C_LSB];
	assign lower_cut_alt_field_a_o = lwb_q[SATC_LC_A_LSB +: 7];
	assign lower_cut_alt_field_b_o = lwb_q[SATC_LC_B_LSB +: 6];
	assign lower_cut_alt_field_c_o = lwb_q[SATC_LC_C_LSB];
	assign step_sel_one_o   = step_q[SATC_ST_1_LSB +: 7];
	assign step_sel_two_o   = step_q[SATC_ST_2_LSB +: 6];
	assign step_sel_three_o = step_q[SATC_ST_3_LSB +: 2];
	assign source_bias_o    = bias_q[SATC_BI_P_LSB +: 4];
	assign sink_bias_o      = bias_q[SATC_BI_N_LSB +: 4];
	// gating is registered, so no decode glitch ever reaches a stimulator
	assign stim_on_o      = stim_on_q; // [R16] [R3]
	assign stim_neg_o     = pol_q; // [R3]
	assign pos_mag_o      = pos_q;
	assign neg_mag_o      = neg_q;
	assign stim_enabled_o = en_q;
endmodule : satc_device
`default_nettype wire

// File: rtl/satc_host.sv
// Purpose: host end that issues configuration commands on a fixed slot grid
// Assumes: device answers every command one cycle after taking it
// Notes:   one command per slot keeps pulse phase timing regular
`timescale 1ns/1ps
`default_nettype none
module satc_host
	import satc_pkg::*;
#(
	parameter int SLOT_CYCLES = SATC_SLOT_CYCLES // cycles between command slots
)
(
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        reset_n_i,
	// link
	satc_link_if.host        link,
	// user request
	input  wire logic        req_valid_i,
	input  wire logic        req_write_i,
	input  wire logic        req_update_i,
	input  wire logic [7:0]  req_addr_i,
	input  wire logic [15:0] req_data_i,
	output logic             req_ready_o,
	// user answer
	output logic             ans_valid_o,
	output logic [15:0]      ans_data_o
);
	// refuse slot lengths the 16-bit divider cannot count
	if (SLOT_CYCLES < 2 || SLOT_CYCLES > 65535)
	begin : g_bad_slot
		$error("SLOT_CYCLES out of range");
	end

	// host states
	typedef enum logic [2:0] {
		SATC_H_IDLE = 3'b001, // ready for a request
		SATC_H_SLOT = 3'b010, // waiting for the next slot
		SATC_H_RESP = 3'b100  // command out, awaiting answer
	} satc_hstate_t;

	satc_hstate_t st_q, st_d;
	logic [15:0]  div_q, div_d;     // slot divider
	logic         tick;             // one-cycle slot enable
	logic         cv_q, cv_d;       // command strobe
	logic         cw_q, cw_d;
	logic         cu_q, cu_d;
	logic [7:0]   ca_q, ca_d;
	logic [15:0]  cd_q, cd_d;
	logic         rdy_q, rdy_d;
	logic         av_q, av_d;
	logic [15:0]  ad_q, ad_d;

	assign tick = (div_q == 16'h0000);

	// next-state: divider, command holding and answer capture
	always_comb
	begin
		st_d  = st_q;
		div_d = tick ? 16'(SLOT_CYCLES - 1) : div_q - 16'h0001; // [R14]
		cv_d  = 1'b0;
		cw_d  = cw_q;
		cu_d  = cu_q;
		ca_d  = ca_q;
		cd_d  = cd_q;
		rdy_d = rdy_q;
		av_d  = 1'b0;
		ad_d  = ad_q;
		unique case (st_q)
			SATC_H_IDLE:
			begin
				if (req_valid_i && rdy_q)
				begin
					// each pulse phase is its own request, e.g. on, flip, off
					cw_d  = req_write_i;  // [R13]
					cu_d  = req_update_i; // [R10]
					ca_d  = req_addr_i;
					cd_d  = req_data_i;   // [R6] [R15] user supplies bias and trim
					rdy_d = 1'b0;
					st_d  = SATC_H_SLOT;
				end
			end
			SATC_H_SLOT:
			begin
				// issuing only on the slot tick fixes phase lengths to the grid
				if (tick) // [R14]
				begin
					cv_d = 1'b1;
					st_d = SATC_H_RESP;
				end
			end
			SATC_H_RESP:
			begin
				if (link.rsp_valid)
				begin
					av_d  = 1'b1;
					ad_d  = link.rsp_data;
					rdy_d = 1'b1;
					st_d  = SATC_H_IDLE;
				end
			end
		endcase
	end

	// register state
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			st_q  <= SATC_H_IDLE;
			div_q <= 16'h0000;
			cv_q  <= 1'b0;
			cw_q  <= 1'b0;
			cu_q  <= 1'b0;
			ca_q  <= 8'h00;
			cd_q  <= 16'h0000;
			rdy_q <= 1'b1;
			av_q  <= 1'b0;
			ad_q  <= 16'h0000;
		end
		else
		begin
			st_q  <= st_d;
			div_q <= div_d;
			cv_q  <= cv_d;
			cw_q  <= cw_d;
			cu_q  <= cu_d;
			ca_q  <= ca_d;
			cd_q  <= cd_d;
			rdy_q <= rdy_d;
			av_q  <= av_d;
			ad_q  <= ad_d;
		end
	end

	assign link.cmd_valid  = cv_q;
	assign link.cmd_write  = cw_q;
	assign link.cmd_update = cu_q;
	assign link.cmd_addr   = ca_q;
	assign link.cmd_data   = cd_q;
	assign req_ready_o     = rdy_q;
	assign ans_valid_o     = av_q;
	assign ans_data_o      = ad_q;
endmodule : satc_host
`default_nettype wire

// File: shared/satc_link_if.sv
// Purpose: command link between host controller and configuration bank
// Assumes: both ends on ref_clk_i
// Notes:   one command per cmd_valid pulse, one response per command
`timescale 1ns/1ps
`default_nettype none
interface satc_link_if;
	logic        cmd_valid;  // one-cycle command strobe
	logic        cmd_write;  // 1 write, 0 read
	logic        cmd_update; // commit flag
	logic [7:0]  cmd_addr;   // register number
	logic [15:0] cmd_data;   // write data
	logic        rsp_valid;  // one-cycle response strobe
	logic [15:0] rsp_data;   // read value or echoed write data
	// device end
	modport device (input cmd_valid, cmd_write, cmd_update, cmd_addr, cmd_data,
	                output rsp_valid, rsp_data);
	// host end
	modport host (output cmd_valid, cmd_write, cmd_update, cmd_addr, cmd_data,
	              input rsp_valid, rsp_data);
endinterface : satc_link_if
`default_nettype wire

// File: shared/satc_pkg.sv
// Purpose: shared constants for the stimulator configuration bank and its host
// Assumes: 8-bit register numbers, 16-bit register data, 40 MHz ref_clk_i
// Notes:   field layouts inside words are fixed here for both ends
package satc_pkg;
	// register numbers
	localparam logic [7:0] SATC_REG_UPPER_A  = 8'h04; // first upper-cut resistor
	localparam logic [7:0] SATC_REG_UPPER_B  = 8'h05; // second upper-cut resistor
	localparam logic [7:0] SATC_REG_LOWER_A  = 8'h06; // lower cut, normal version
	localparam logic [7:0] SATC_REG_LOWER_B  = 8'h07; // lower cut, recovery version
	localparam logic [7:0] SATC_REG_UNLOCK_L = 8'h20; // unlock code, low half
	localparam logic [7:0] SATC_REG_UNLOCK_H = 8'h21; // unlock code, high half
	localparam logic [7:0] SATC_REG_STEP     = 8'h22; // global step size selects
	localparam logic [7:0] SATC_REG_BIAS     = 8'h23; // source and sink bias
	localparam logic [7:0] SATC_REG_ON       = 8'h2A; // per-channel on/off
	localparam logic [7:0] SATC_REG_POL      = 8'h2C; // per-channel polarity
	localparam logic [7:0] SATC_REG_POS_BASE = 8'h40; // positive magnitudes 64..79
	localparam logic [7:0] SATC_REG_NEG_BASE = 8'h60; // negative magnitudes 96..111
	// field positions: upper cut resistor word
	localparam int SATC_UC_COARSE_LSB = 0;  // 6-bit coarse select
	localparam int SATC_UC_FINE_LSB   = 6;  // 5-bit fine select
	// lower cut word
	localparam int SATC_LC_A_LSB = 0;  // 7-bit field a
	localparam int SATC_LC_B_LSB = 7;  // 6-bit field b
	localparam int SATC_LC_C_LSB = 13; // 1-bit field c
	// step word
	localparam int SATC_ST_1_LSB = 0;  // 7-bit increment select one
	localparam int SATC_ST_2_LSB = 7;  // 6-bit increment select two
	localparam int SATC_ST_3_LSB = 13; // 2-bit increment select three
	// bias word
	localparam int SATC_BI_P_LSB = 0;  // 4-bit source bias
	localparam int SATC_BI_N_LSB = 4;  // 4-bit sink bias
	// magnitude word: code low byte, trim high byte
	localparam int SATC_MAG_LSB  = 0;
	localparam int SATC_TRIM_LSB = 8;
	// values after reset
	localparam logic [15:0] SATC_RST_WORD = 16'h0000; // all config words
	localparam logic [15:0] SATC_RST_TRIM = 16'h8000; // mid trim, zero magnitude
	// unlock code, value arbitrary
	localparam logic [31:0] SATC_UNLOCK_CODE = 32'hC3A5_5A3C;
	// host command slot
	localparam int SATC_CLK_MHZ      = 40;
	localparam int SATC_SLOT_NS      = 1000; // command slot period
	localparam int SATC_SLOT_CYCLES  = (SATC_SLOT_NS * SATC_CLK_MHZ + 999) / 1000;
	localparam int SATC_CHANNELS     = 16;
endpackage : satc_pkg

// File: verif/satc_link_chk.sv
// Purpose: link checker for the stimulator configuration bank
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   models the on-bit shadow from the wire to judge read-back
`timescale 1ns/1ps
`default_nettype none
module satc_link_chk
	import satc_pkg::*;
#(
	parameter int SLOT_CYCLES = SATC_SLOT_CYCLES // host slot spacing
)
(
	// clock and reset
	input wire logic        ref_clk_i,
	input wire logic        reset_n_i,
	// link signals
	input wire logic        cmd_valid,
	input wire logic        cmd_write,
	input wire logic        cmd_update,
	input wire logic [7:0]  cmd_addr,
	input wire logic [15:0] cmd_data,
	input wire logic        rsp_valid,
	input wire logic [15:0] rsp_data
);
	logic [15:0] gap_q, gap_d; // cycles since last command, restarts at 1 on each command
	logic        seen_q, seen_d; // first command already sent
	logic [15:0] shd_q, shd_d; // shadow of the on-bit word
	logic [15:0] act_q, act_d; // active on-bit word
	logic        map_w; // address decodes to a register
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	// decode mapped register numbers
	always_comb
	begin
		map_w = cmd_addr inside {[8'h04:8'h07], [8'h20:8'h23], SATC_REG_ON, SATC_REG_POL,
			[8'h40:8'h4F], [8'h60:8'h6F]};
	end
	// next values of the helper model
	always_comb
	begin
		gap_d  = cmd_valid ? 16'h0001 : gap_q + 16'h0001;
		seen_d = seen_q | cmd_valid;
		shd_d  = (cmd_valid && cmd_write && cmd_addr == SATC_REG_ON) ? cmd_data : shd_q;
		act_d  = (cmd_valid && cmd_update) ? shd_d : act_q; // same-command write counts
	end
	// helper registers
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			gap_q  <= 16'h0000;
			seen_q <= 1'b0;
			shd_q  <= 16'h0000;
			act_q  <= 16'h0000;
		end
		else
		begin
			gap_q  <= gap_d;
			seen_q <= seen_d;
			shd_q  <= shd_d;
			act_q  <= act_d;
		end
	end
	sequence s_cmd_rsp;
		cmd_valid ##1 rsp_valid;
	endsequence
	a_rsp_follows: assert property (cmd_valid |-> s_cmd_rsp)
		else $error("command without answer one cycle later");
	a_rsp_caused: assert property (rsp_valid |-> $past(cmd_valid))
		else $error("answer without command");
	a_cmd_pulse: assert property (cmd_valid |=> !cmd_valid)
		else $error("command strobe longer than one cycle");
	a_slot_grid: assert property (cmd_valid && seen_q |-> (int'(gap_q) % SLOT_CYCLES) == 0)
		else $error("command off the slot grid");
	a_write_echo: assert property (cmd_valid && cmd_write |=> rsp_data == $past(cmd_data))
		else $error("write answer does not echo data");
	a_data_holds: assert property (!rsp_valid |-> $stable(rsp_data))
		else $error("answer data changed between answers");
	a_read_active: assert property (cmd_valid && !cmd_write && !cmd_update &&
		cmd_addr == SATC_REG_ON |=> rsp_data == $past(act_q))
		else $error("on-bit read is not the active copy");
	a_unmapped_zero: assert property (cmd_valid && !cmd_write && !map_w |=> rsp_data == 16'h0000)
		else $error("unmapped read not zero");
endmodule : satc_link_chk
`default_nettype wire

// File: verif/stim_amp_triggered_config_tb_top.sv
// Purpose: drives the host user side and judges the device outputs
// Assumes: host slot shortened to 4 cycles
// Notes:   inputs change 2 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module stim_amp_triggered_config_tb_top;
	import satc_pkg::*;
	localparam int SLOT = 4; // short slot keeps the run brief
	logic ref_clk_i = 1'b0, reset_n_i = 1'b0, stim_arm_i = 1'b0; // clock, reset, arm pin
	logic req_valid_i = 1'b0, req_write_i = 1'b0, req_update_i = 1'b0; // user request
	logic [7:0] req_addr_i = 8'h00; // request register number
	logic [15:0] req_data_i = 16'h0000; // request data
	logic req_ready_o, ans_valid_o, en; // host status, enable out
	logic [15:0] ans_data_o, rd, on, neg; // answers, active bits
	logic [5:0] u1c, u2c, lab, lbb, s2; // coarse and six-bit fields
	logic [4:0] u1f, u2f; // fine fields
	logic [6:0] laa, lba, s1; // seven-bit fields
	logic lac, lbc; // one-bit fields
	logic [1:0] s3; // step select three
	logic [3:0] pb, nb; // biases
	logic [15:0][15:0] pm, nm; // active magnitude words
	int num_errors = 0, n_compared = 0; // counters
	satc_link_if link_bus();
	satc_device i_satc_device (.ref_clk_i, .reset_n_i, .link(link_bus.device), .stim_arm_i,
		.upper_cut_first_res_coarse_o(u1c), .upper_cut_first_res_fine_o(u1f),
		.upper_cut_second_res_coarse_o(u2c), .upper_cut_second_res_fine_o(u2f),
		.lower_cut_field_a_o(laa), .lower_cut_field_b_o(lab), .lower_cut_field_c_o(lac),
		.lower_cut_alt_field_a_o(lba), .lower_cut_alt_field_b_o(lbb),
		.lower_cut_alt_field_c_o(lbc), .step_sel_one_o(s1), .step_sel_two_o(s2),
		.step_sel_three_o(s3), .source_bias_o(pb), .sink_bias_o(nb), .stim_on_o(on),
		.stim_neg_o(neg), .pos_mag_o(pm), .neg_mag_o(nm), .stim_enabled_o(en));
	satc_host #(.SLOT_CYCLES(SLOT)) i_satc_host (.ref_clk_i, .reset_n_i,
		.link(link_bus.host), .req_valid_i, .req_write_i, .req_update_i, .req_addr_i,
		.req_data_i, .req_ready_o, .ans_valid_o, .ans_data_o);
	satc_link_chk #(.SLOT_CYCLES(SLOT)) i_chk (.ref_clk_i, .reset_n_i,
		.cmd_valid(link_bus.cmd_valid), .cmd_write(link_bus.cmd_write),
		.cmd_update(link_bus.cmd_update), .cmd_addr(link_bus.cmd_addr),
		.cmd_data(link_bus.cmd_data), .rsp_valid(link_bus.rsp_valid),
		.rsp_data(link_bus.rsp_data));
	// 40 MHz clock
	always #12.5 ref_clk_i = ~ref_clk_i;
	// compare one value, count and report
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk
	// one request through the host; held one edge, taken while ready is high
	task automatic op(input logic w, input logic u, input logic [7:0] a, input logic [15:0] d);
		int k;
		req_valid_i = 1'b1;
		req_write_i = w;
		req_update_i = u;
		req_addr_i = a;
		req_data_i = d;
		@(posedge ref_clk_i);
		#2;
		req_valid_i = 1'b0;
		for (k = 0; k < 20 && ans_valid_o !== 1'b1; k++)
		begin
			@(posedge ref_clk_i);
			#2;
		end
		chk(16'(ans_valid_o), 16'h0001);
		rd = ans_data_o;
	endtask : op
	// let n edges pass, stay 2 ns after the edge
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
		#2;
	endtask : wait_cyc
	// state after reset
	task automatic t_reset;
		chk(on, 16'h0000);
		chk(pm[3], SATC_RST_TRIM);
		chk(16'(en), 16'h0000);
		chk(16'(req_ready_o), 16'h0001);
		$display("t_reset done");
	endtask : t_reset
	// bandwidth words with nonzero fine fields expose field positions
	task automatic t_band;
		op(1'b1, 1'b0, SATC_REG_UPPER_A, 16'((2 << SATC_UC_FINE_LSB) | 46));
		op(1'b1, 1'b0, SATC_REG_UPPER_B, 16'((3 << SATC_UC_FINE_LSB) | 30));
		op(1'b1, 1'b0, SATC_REG_LOWER_A, 16'((1 << SATC_LC_C_LSB) | (60 << SATC_LC_B_LSB) | 16));
		op(1'b1, 1'b0, SATC_REG_LOWER_B, 16'd10);
		chk(16'(u1c), 16'd46);
		chk(16'(u1f), 16'd2);
		chk(16'(u2c), 16'd30);
		chk(16'(u2f), 16'd3);
		chk(16'({lac, lab, laa}), 16'((1 << 13) | (60 << 7) | 16));
		chk(16'({lbc, lbb, lba}), 16'd10);
		op(1'b0, 1'b0, SATC_REG_UPPER_B, 16'h0000);
		chk(rd, 16'((3 << SATC_UC_FINE_LSB) | 30));
		op(1'b1, 1'b0, 8'hFF, 16'hBEEF);
		op(1'b0, 1'b0, 8'hFF, 16'h0000);
		chk(rd, 16'h0000);
		$display("t_band done");
	endtask : t_band
	// the two step sizes at the ends of the table, with matching biases
	task automatic t_step;
		int s1e [2] = '{64, 15};
		int s2e [2] = '{19, 0};
		int s3e [2] = '{3, 0};
		int be [2] = '{6, 15};
		for (int i = 0; i < 2; i++)
		begin
			op(1'b1, 1'b0, SATC_REG_STEP, 16'((s3e[i] << 13) | (s2e[i] << 7) | s1e[i]));
			op(1'b1, 1'b0, SATC_REG_BIAS, 16'((be[i] << SATC_BI_N_LSB) | be[i]));
			chk(16'({s3, s2, s1}), 16'((s3e[i] << 13) | (s2e[i] << 7) | s1e[i]));
			chk(16'({nb, pb}), 16'((be[i] << 4) | be[i]));
		end
		$display("t_step done");
	endtask : t_step
	// shadow writes, commit on a read, hold, then a biphasic pulse
	task automatic t_trig;
		stim_arm_i = 1'b1;
		op(1'b1, 1'b0, SATC_REG_UNLOCK_L, SATC_UNLOCK_CODE[15:0]);
		op(1'b1, 1'b0, SATC_REG_UNLOCK_H, SATC_UNLOCK_CODE[31:16]);
		chk(16'(en), 16'h0001);
		op(1'b1, 1'b0, SATC_REG_ON, 16'h8001);
		op(1'b1, 1'b0, SATC_REG_POL, 16'h0001);
		op(1'b1, 1'b0, SATC_REG_POS_BASE, 16'h40C8);
		op(1'b1, 1'b0, SATC_REG_NEG_BASE + 8'h0F, 16'h3F11);
		chk(on, 16'h0000);
		chk(pm[0], SATC_RST_TRIM);
		op(1'b0, 1'b0, SATC_REG_ON, 16'h0000);
		chk(rd, 16'h0000);
		op(1'b0, 1'b1, SATC_REG_BIAS, 16'h0000);
		chk(on, 16'h8001);
		chk(neg, 16'h0001);
		chk(pm[0], 16'h40C8);
		chk(nm[15], 16'h3F11);
		wait_cyc(50);
		chk(on, 16'h8001);
		op(1'b1, 1'b1, SATC_REG_POL, 16'h0000);
		chk(neg, 16'h0000);
		chk(on, 16'h8001);
		op(1'b1, 1'b1, SATC_REG_ON, 16'h0000);
		chk(on, 16'h0000);
		op(1'b1, 1'b1, SATC_REG_POS_BASE, 16'h48C8);
		chk(pm[0], 16'h48C8);
		$display("t_trig done");
	endtask : t_trig
	// arm pin low or a wrong key keeps every stimulator off
	task automatic t_lock;
		op(1'b1, 1'b1, SATC_REG_ON, 16'h0003);
		chk(on, 16'h0003);
		stim_arm_i = 1'b0;
		wait_cyc(4);
		chk(on, 16'h0000);
		stim_arm_i = 1'b1;
		op(1'b1, 1'b0, SATC_REG_UNLOCK_L, SATC_UNLOCK_CODE[15:0] ^ 16'h0001);
		wait_cyc(4);
		chk(16'(en), 16'h0000);
		op(1'b1, 1'b0, SATC_REG_UNLOCK_L, SATC_UNLOCK_CODE[15:0]);
		wait_cyc(4);
		chk(on, 16'h0003);
		$display("t_lock done");
	endtask : t_lock
	// counts and verdict, then end of run
	task automatic test_done;
		$display("compared %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done
	// main sequence
	initial
	begin
		wait_cyc(2);
		reset_n_i = 1'b1;
		t_reset();
		t_band();
		t_step();
		t_trig();
		t_lock();
		test_done();
	end
	// watchdog, far beyond the expected run
	initial
	begin
		#500000;
		num_errors++;
		test_done();
	end
endmodule : stim_amp_triggered_config_tb_top
`default_nettype wire
